/* File: uic_map.svh */
// Offsets, field positions and reset values of the event status block
`ifndef UIC_MAP_SVH
`define UIC_MAP_SVH

`define UIC_OFF_RAW      12'h03c
`define UIC_OFF_MASKED   12'h040
`define UIC_OFF_CLEAR    12'h044
`define UIC_OFF_ENABLE   12'h038
`define UIC_OFF_IRQSTAT  12'h048
`define UIC_OFF_IRQMASK  12'h04c

`define UIC_BIT_RX       4
`define UIC_BIT_TX       5
`define UIC_BIT_RTO      6
`define UIC_BIT_FRAME    7
`define UIC_BIT_PARITY   8
`define UIC_BIT_BREAK    9
`define UIC_BIT_OVERRUN  10
`define UIC_EV_LSB       4
`define UIC_EV_MSB       10

`define UIC_RST_EVENTS   7'h00
`define UIC_RST_ENABLE   7'h00
`define UIC_RST_IRQMASK  2'h0
`define UIC_RST_IRQSTAT  2'h0

`endif

/* File: uic_pkg.sv */
// Types shared by the event status block
package uic_pkg;
   // One bit per event, index 0 is receive, 6 is overrun
   typedef logic [6:0] uic_ev_t;

   // Register port request
   typedef struct packed {
      logic [11:0] addr;
      logic [31:0] wdata;
      logic        wr;
      logic        rd;
   } uic_req_t;

   // Whole state of the block
   typedef struct packed {
      uic_ev_t     raw;
      uic_ev_t     enable;
      logic [1:0]  irq_stat;
      logic [1:0]  irq_mask;
      logic [31:0] rdata;
      logic        masked_any;
   } uic_state_t;
endpackage

/* File: uic_event_status.sv */
// Masked event status and write-one-to-clear logic of a serial port
//
// Contract
// R1: Masked status register readable at 0x040.
// R2: Masked reads show live post-mask state.
// R3: Writes to masked status are ignored.
// R4: Clear register decoded at 0x044.
// R5: Writing one clears raw and masked.
// R6: Writing zero leaves event untouched.
// R7: Raw status readable at 0x03C, same bits.
// R8: Software clears by writing ones only.
// R9: Masked equals raw AND enable; fixed positions.
`timescale 1ns/100ps
`include "uic_map.svh"

module uic_event_status
   import uic_pkg::*;
(
   input  wire logic        clk_sys,    // System clock, 40 MHz
   input  wire logic        rst,        // Synchronous reset, active high
   input  wire logic [11:0] reg_addr,   // Register byte address
   input  wire logic [31:0] reg_wdata,  // Write data
   input  wire logic        reg_wr,     // Write strobe
   input  wire logic        reg_rd,     // Read strobe
   output logic      [31:0] reg_rdata,  // Read data, cycle after strobe
   input  wire logic [6:0]  ev_set,     // Event pulses, receive at bit 0
   output logic      [6:0]  ev_masked,  // Live masked events
   output logic             irq         // Level interrupt
);

   // Register request as one word, and the whole block state
   uic_req_t    req;                  // Register port bundle
   uic_state_t  st_r;                 // Registered state
   uic_state_t  st_nxt;               // State for the next edge

   // Address matches, one per mapped register
   logic        hit_raw;              // Raw status word
   logic        hit_masked;           // Masked status word
   logic        hit_clear;            // Event clear word
   logic        hit_enable;           // Event enable word
   logic        hit_irqstat;          // Interrupt status word
   logic        hit_irqmask;          // Interrupt mask word

   // Strobes qualified by the address
   logic        wr_clear;             // Write to event clear
   logic        wr_enable;            // Write to event enable
   logic        wr_irqmask;           // Write to interrupt mask
   logic        rd_raw;               // Read of raw status
   logic        rd_masked;            // Read of masked status
   logic        rd_enable;            // Read of event enable
   logic        rd_irqstat;           // Read of interrupt status
   logic        rd_irqmask;           // Read of interrupt mask

   // Event vectors, receive at index 0, and the interrupt status set pulses
   uic_ev_t     masked;               // Raw AND enable, live
   uic_ev_t     clr;                  // Events picked by a clear write
   uic_ev_t     raw_nxt;              // Raw events after set and clear
   uic_ev_t     ev_new;               // Enabled events not yet pending
   logic [1:0]  irq_ev;               // Interrupt status set pulses

   // Masked event lanes by name
   logic        rx_event_masked;      // Receive
   logic        tx_event_masked;      // Transmit
   logic        rx_timeout_masked;    // Receive time-out
   logic        framing_err_masked;   // Framing error
   logic        parity_err_masked;    // Parity error
   logic        break_masked;         // Break
   logic        overrun_masked;       // Overrun

   // Register words as software sees them
   logic [31:0] raw_event_status;     // Raw view, reserved bits zero
   logic [31:0] masked_event_status;  // Masked view, reserved bits zero
   logic [31:0] enable_word;          // Enable view
   logic [31:0] irqstat_word;         // Interrupt status view
   logic [31:0] irqmask_word;         // Interrupt mask view
   logic [31:0] rdata_nxt;            // Read data for the next cycle

   // Bundle the register port
   assign req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};

   // Decode the byte address, one compare per mapped word
   assign hit_raw     = (req.addr == `UIC_OFF_RAW);                  // [R7]
   assign hit_masked  = (req.addr == `UIC_OFF_MASKED);               // [R1]
   assign hit_clear   = (req.addr == `UIC_OFF_CLEAR);                // [R4]
   assign hit_enable  = (req.addr == `UIC_OFF_ENABLE);
   assign hit_irqstat = (req.addr == `UIC_OFF_IRQSTAT);
   assign hit_irqmask = (req.addr == `UIC_OFF_IRQMASK);

   // Write strobes; the masked and raw views take none
   assign wr_clear   = req.wr & hit_clear;                           // [R4]
   assign wr_enable  = req.wr & hit_enable;
   assign wr_irqmask = req.wr & hit_irqmask;

   // Read strobes; the clear word has no read path and reads zero
   assign rd_raw     = req.rd & hit_raw;                             // [R7]
   assign rd_masked  = req.rd & hit_masked;                          // [R1]
   assign rd_enable  = req.rd & hit_enable;
   assign rd_irqstat = req.rd & hit_irqstat;
   assign rd_irqmask = req.rd & hit_irqmask;

   // Live masked view of every event
   assign masked = st_r.raw & st_r.enable;                           // [R9]

   // Name each masked lane at its fixed position
   assign rx_event_masked    = masked[`UIC_BIT_RX - `UIC_EV_LSB];      // [R9]
   assign tx_event_masked    = masked[`UIC_BIT_TX - `UIC_EV_LSB];      // [R9]
   assign rx_timeout_masked  = masked[`UIC_BIT_RTO - `UIC_EV_LSB];     // [R9]
   assign framing_err_masked = masked[`UIC_BIT_FRAME - `UIC_EV_LSB];   // [R9]
   assign parity_err_masked  = masked[`UIC_BIT_PARITY - `UIC_EV_LSB];  // [R9]
   assign break_masked       = masked[`UIC_BIT_BREAK - `UIC_EV_LSB];   // [R9]
   assign overrun_masked     = masked[`UIC_BIT_OVERRUN - `UIC_EV_LSB]; // [R9]

   // Ones written to the clear register select events to drop
   always_comb begin
      clr = '0;
      if (wr_clear) begin                                            // [R4]
         clr = req.wdata[`UIC_EV_MSB:`UIC_EV_LSB];                   // [R5] [R6] [R8]
      end
   end

   // Per event lane: raw next value and fresh-event detect
   for (genvar i = 0; i < $bits(uic_ev_t); i++) begin : g_lane
      // Set beats clear so an event arriving with the clear is kept
      assign raw_nxt[i] = ev_set[i] | (st_r.raw[i] & ~clr[i]);       // [R5] [R6]
      // Enabled event that was not already pending
      assign ev_new[i]  = ev_set[i] & st_r.enable[i] & ~st_r.raw[i];
   end

   // Interrupt status bit 0: a fresh masked event, or the masked view turning non-empty
   assign irq_ev[0] = (|ev_new) | ((|masked) & ~st_r.masked_any);
   // Interrupt status bit 1: software wrote ones to event bits 10:4 of the clear register
   assign irq_ev[1] = |clr;

   // Raw word: events in their lanes, reserved bits read zero
   assign raw_event_status = {21'h0, st_r.raw, 4'h0};                // [R7]

   // Masked word built lane by lane, reserved bits read zero
   assign masked_event_status = {21'h0,
                                 overrun_masked,
                                 break_masked,
                                 parity_err_masked,
                                 framing_err_masked,
                                 rx_timeout_masked,
                                 tx_event_masked,
                                 rx_event_masked,
                                 4'h0};                              // [R1] [R2] [R9]

   // Control words, unused bits read zero
   assign enable_word  = {21'h0, st_r.enable, 4'h0};
   assign irqstat_word = {30'h0, st_r.irq_stat};
   assign irqmask_word = {30'h0, st_r.irq_mask};

   // Read data for the cycle after the strobe; idle and unmapped read zero
   always_comb begin
      rdata_nxt = 32'h0;
      if (rd_raw) begin
         rdata_nxt = raw_event_status;                               // [R7]
      end else if (rd_masked) begin
         rdata_nxt = masked_event_status;                            // [R1] [R2]
      end else if (rd_enable) begin
         rdata_nxt = enable_word;
      end else if (rd_irqstat) begin
         rdata_nxt = irqstat_word;
      end else if (rd_irqmask) begin
         rdata_nxt = irqmask_word;
      end
   end

   // Next state of every register
   always_comb begin
      // Hold everything; the masked and raw words have no write path
      st_nxt = st_r;                                                 // [R3]
      st_nxt.raw = raw_nxt;                                          // [R5] [R6]
      // One cycle memory of a non-empty masked view
      st_nxt.masked_any = |masked;
      // Enable write
      if (wr_enable) begin
         st_nxt.enable = req.wdata[`UIC_EV_MSB:`UIC_EV_LSB];
      end
      // Interrupt mask write
      if (wr_irqmask) begin
         st_nxt.irq_mask = req.wdata[1:0];
      end
      // Sticky status; its read clears it but a new event still wins
      if (rd_irqstat) begin
         st_nxt.irq_stat = irq_ev;
      end else begin
         st_nxt.irq_stat = st_r.irq_stat | irq_ev;
      end
      // Read data stands for one cycle only
      st_nxt.rdata = rdata_nxt;
   end

   // State register
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         st_r.raw        <= `UIC_RST_EVENTS;
         st_r.enable     <= `UIC_RST_ENABLE;
         st_r.irq_stat   <= `UIC_RST_IRQSTAT;
         st_r.irq_mask   <= `UIC_RST_IRQMASK;
         st_r.rdata      <= '0;
         st_r.masked_any <= 1'b0;
      end else begin
         st_r <= st_nxt;
      end
   end

   // Outputs
   assign reg_rdata = st_r.rdata;
   assign ev_masked = masked;                                        // [R9]
   // Level interrupt while an unmasked status bit stands
   assign irq       = |(st_r.irq_stat & st_r.irq_mask);

endmodule

/* File: uic_event_status_asserts.sv */
// Checker for the event status block
`timescale 1ns/100ps
module uic_event_status_asserts (
   input wire logic        clk_sys,   // Clock
   input wire logic        rst,       // Reset
   input wire logic [11:0] reg_addr,  // Addr
   input wire logic [31:0] reg_wdata, // Data
   input wire logic        reg_wr,    // Write
   input wire logic        reg_rd,    // Read
   input wire logic [31:0] reg_rdata, // Rdata
   input wire logic [6:0]  ev_set,    // Events
   input wire logic [6:0]  ev_masked, // Masked
   input wire logic        irq        // Irq
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (rst);
   wire rd_m = reg_rd && reg_addr == 12'h040;
   wire rd_r = reg_rd && reg_addr == 12'h03c;
   wire wr_c = reg_wr && reg_addr == 12'h044;
   // Reads, clears and ignored writes
   a_rd_masked: assert property (rd_m |=> reg_rdata == {21'h0, $past(ev_masked), 4'h0})
      else $error("masked read");
   a_rd_idle: assert property (!reg_rd |=> reg_rdata == 32'h0) else $error("idle rdata");
   a_clr_one: assert property (wr_c && reg_wdata[10] && !ev_set[6] |=> !ev_masked[6])
      else $error("clear one");
   a_clr_zero: assert property (wr_c && !reg_wdata[5] && ev_masked[1] |=> ev_masked[1])
      else $error("clear zero");
   a_ro_write: assert property (reg_wr && reg_addr == 12'h040 && ev_set == 7'h00 |=>
      $stable(ev_masked)) else $error("ro write");
   a_unmapped_rd: assert property (reg_rd && reg_addr == 12'h100 |=> reg_rdata == 32'h0)
      else $error("unmapped");
   a_rsvd_zero: assert property (rd_m || rd_r |=> reg_rdata[31:11] == 21'h0 &&
      reg_rdata[3:0] == 4'h0) else $error("reserved");
   a_raw_super: assert property (rd_r |=> (reg_rdata[10:4] & $past(ev_masked)) ==
      $past(ev_masked)) else $error("raw read");
   c_masked: cover property (rd_m ##1 reg_rdata != 32'h0);
   c_clear: cover property (wr_c);
   c_irq: cover property ($rose(irq));
endmodule
bind uic_event_status uic_event_status_asserts u_chk (.*);

/* File: uic_event_status_tb_top.sv */
// Testbench for the event status block
`timescale 1ns/100ps
module uic_event_status_tb_top;
   logic        clk_sys = 0, rst = 1, reg_wr = 0, reg_rd = 0, irq;
   logic [11:0] reg_addr = 12'h0;
   logic [31:0] reg_wdata = 32'h0, reg_rdata;
   logic [6:0]  ev_set = 7'h00, ev_masked;
   int          miscompares = 0, n_compared = 0;
   always #12.5 clk_sys = ~clk_sys;
   uic_event_status DUT (.*);
   task cmp(input string n, input logic [31:0] e, g);
      n_compared++;
      if (g !== e) begin
         miscompares++;
         $display("mismatch %s exp %h got %h", n, e, g);
      end
   endtask
   task wr(input logic [11:0] a, input logic [31:0] d);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk_sys) reg_wr <= 1'b0;
      @(posedge clk_sys);
   endtask
   task rd(input logic [11:0] a, input logic [31:0] e);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk_sys) reg_rd <= 1'b0;
      #1 cmp("rdata", e, reg_rdata);
      @(posedge clk_sys);
   endtask
   // Enable, raise, ignored write, live view
   task t_mask;
      wr(12'h038, 32'h550);
      ev_set <= 7'h7f;
      @(posedge clk_sys) ev_set <= 7'h00;
      rd(12'h03c, 32'h7f0);
      rd(12'h040, 32'h550);
      cmp("ev_masked", 32'h55, {25'h0, ev_masked});
      wr(12'h040, 32'hffffffff);
      rd(12'h040, 32'h550);
      wr(12'h038, 32'h7f0);
      rd(12'h040, 32'h7f0);
   endtask
   task t_clear;
      wr(12'h044, 32'h410);
      rd(12'h03c, 32'h3e0);
      rd(12'h040, 32'h3e0);
      wr(12'h044, 32'h0);
      rd(12'h03c, 32'h3e0);
      rd(12'h100, 32'h0);
   endtask
   task t_irq;
      wr(12'h04c, 32'h1);
      cmp("irq", 32'h1, irq);
      wr(12'h04c, 32'h0);
      cmp("irq", 32'h0, irq);
      wr(12'h044, 32'h7f0);
      wr(12'h04c, 32'h1);
      rd(12'h048, 32'h3);
      cmp("irq", 32'h0, irq);
   endtask
   task wrap_up;
      $display("compared %0d miscompares %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   initial begin
      repeat (10) @(posedge clk_sys);
      rst <= 1'b0;
      @(posedge clk_sys);
      rd(12'h040, 32'h0);
      t_mask;
      t_clear;
      t_irq;
      wrap_up;
   end
endmodule
